// File: src/bank_ctrl_pkg.sv
// Purpose: shared constants for the bank wait and host port control block
// Assumes: apb data 32 bits, register word 16 bits in the low half
// Notes:   offsets are byte addresses on the apb side
package bank_ctrl_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_CTRL       = 12'h000;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h004;
   localparam logic [11:0] OFS_IRQ_MASK   = 12'h008;
   localparam logic [11:0] OFS_BUS_STATUS = 12'h00C;

   // control word field positions
   localparam int CMP_MSB   = 15;
   localparam int CMP_LSB   = 12;
   localparam int GAP_BIT   = 11;
   localparam int BOOT_BIT  = 4;
   localparam int HIRQ_BIT  = 3;
   localparam int MODE_BIT  = 2;
   localparam int BOFF_BIT  = 0;

   // control word reset value and writable bits
   localparam logic [15:0] CTRL_RESET = 16'hF800;
   localparam logic [15:0] CTRL_WMASK = 16'hFFFF;

   // interrupt event bit positions
   localparam int EV_BANK_WAIT = 0;
   localparam int EV_READ_GAP  = 1;
   localparam int EV_BUS_OFF   = 2;
   localparam int EV_RAM_DROP  = 3;
   localparam int EV_COUNT     = 4;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   // bus status bit positions
   localparam int ST_BUS_OFF = 0;
   localparam int ST_BOOT    = 1;
   localparam int ST_BUSY    = 2;

   // address space codes on the processor request port
   typedef enum logic [1:0] {
      SPACE_PROG = 2'b00,
      SPACE_DATA = 2'b01,
      SPACE_IO   = 2'b10
   } space_e;

   // external cycle sequencer, gray codes along the path through the wait state
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_WAIT   = 2'b01,
      SEQ_ACCESS = 2'b11,
      SEQ_DONE   = 2'b10
   } seq_e;

endpackage

// File: src/irq_event_if.sv
// Purpose: carrier between the control block and its interrupt unit
// Assumes: single clock domain
// Notes:   events are one-cycle pulses except the ram drop level, clears are write-one pulses
`timescale 1ns/10ps
interface irq_event_if #(parameter int N = 4);
   logic [N-1:0] event_pulse;
   logic [N-1:0] clear;
   logic         mask_wr;
   logic [N-1:0] mask_data;
   logic [N-1:0] status;
   logic [N-1:0] mask;

   modport ctrl (output event_pulse, output clear, output mask_wr,
                 output mask_data, input status, input mask);
   modport unit (input event_pulse, input clear, input mask_wr,
                 input mask_data, output status, output mask);
endinterface

// File: src/irq_unit.sv
// Purpose: sticky event status, mask and one level interrupt
// Assumes: clears arrive as one-cycle pulses, events as pulses except the ram drop level
// Notes:   a set in the same cycle as its clear wins
`timescale 1ns/10ps
module irq_unit
   import bank_ctrl_pkg::*;
#(
   parameter int N = EV_COUNT
) (
   input  wire logic   clk,
   input  wire logic   reset,
   irq_event_if.unit   ev,
   output logic        irq
);

   logic [N-1:0] status;
   logic [N-1:0] mask;
   logic [N-1:0] next_status;

   // clear first, then set so a new event is never lost
   assign next_status = (status & ~ev.clear) | ev.event_pulse;

   // status and mask storage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= '0;
         mask   <= N'(IRQ_MASK_RESET);
      end else begin
         status <= next_status;
         if (ev.mask_wr) begin
            mask <= ev.mask_data;
         end
      end
   end

   // level output while any unmasked bit is set
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & mask);
      end
   end

   assign ev.status = status;
   assign ev.mask   = mask;

endmodule

// File: src/bank_wait_ctrl.sv
// Purpose: bank wait and host port control register with the logic it steers
// Assumes: apb slave, zero wait states; one external access at a time
// Notes:   external pins are split into input, output and output enable
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module bank_wait_ctrl
   import bank_ctrl_pkg::*;
#(
   parameter int AW = 16,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          reset,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // processor external access port
   input  wire logic          cpu_req,
   input  wire logic [1:0]    cpu_space,
   input  wire logic          cpu_we,
   input  wire logic [AW-1:0] cpu_addr,
   input  wire logic [DW-1:0] cpu_wdata,
   output logic               cpu_ready,
   output logic [DW-1:0]      cpu_rdata,
   // external memory bus pins
   output logic [AW-1:0]      ext_addr,
   output logic [DW-1:0]      ext_data_o,
   output logic               ext_data_oe,
   input  wire logic [DW-1:0] ext_data_i,
   output logic               prog_sel_n,
   output logic               data_sel_n,
   output logic               io_sel_n,
   output logic               mem_strobe_n,
   output logic               io_strobe_n,
   output logic               rw_n,
   // boot select and host interrupt
   input  wire logic          shared_ram_boot_select_n,
   output logic               boot_from_shared_ram,
   output logic               host_irq_bit,
   // shared host ram port, processor side
   input  wire logic          ram_cpu_we,
   input  wire logic [DW-1:0] ram_cpu_rdata_in,
   output logic               ram_we_out,
   output logic [DW-1:0]      ram_cpu_rdata,
   // shared host ram port, host side
   input  wire logic          cpu_idle,
   input  wire logic          host_ram_req,
   output logic               host_ram_grant,
   // mode and hold bit write permission
   input  wire logic          mode_status_wr,
   output logic               mode_status_wr_ok,
   input  wire logic          hold_mode_wr,
   output logic               hold_mode_wr_ok,
   // interrupt to the local processor
   output logic               irq
);

   // control register and its fields
   logic [15:0] bank_wait_control_register;
   logic [3:0]  bank_compare_mask;
   logic        prog_data_read_gap;
   logic        boot_mode_override;
   logic        shared_ram_mode;
   logic        external_bus_off;

   // field views of the control word
   assign bank_compare_mask  = bank_wait_control_register[CMP_MSB:CMP_LSB];
   assign prog_data_read_gap = bank_wait_control_register[GAP_BIT];
   assign boot_mode_override = bank_wait_control_register[BOOT_BIT];
   assign shared_ram_mode    = bank_wait_control_register[MODE_BIT];
   assign external_bus_off   = bank_wait_control_register[BOFF_BIT];

   // apb decode
   logic apb_wr;
   logic apb_rd;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_mask;
   logic hit_bus;
   logic hit_any;

   assign hit_ctrl = (paddr == OFS_CTRL);
   assign hit_stat = (paddr == OFS_IRQ_STATUS);
   assign hit_mask = (paddr == OFS_IRQ_MASK);
   assign hit_bus  = (paddr == OFS_BUS_STATUS);
   assign hit_any  = hit_ctrl | hit_stat | hit_mask | hit_bus;
   assign apb_wr   = psel & penable & pwrite & hit_any;
   assign apb_rd   = psel & penable & ~pwrite;

   // zero wait slave, error only on unmapped offsets
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // whole word written in one access, reserved bits keep what was written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bank_wait_control_register <= CTRL_RESET;
      end else if (apb_wr && hit_ctrl) begin
         bank_wait_control_register <= pwdata[15:0] & CTRL_WMASK;
      end
   end

   // external access sequencer
   seq_e            state;
   seq_e            next_state;
   logic [AW-1:0]   last_addr;
   logic [1:0]      last_space;
   logic            last_read;
   logic            have_last;
   logic [1:0]      cur_space;
   logic            cur_we;
   logic [DW-1:0]   cur_wdata;
   logic            bus_off_active;
   logic            bank_cross;
   logic            space_cross;
   logic            read_turn;
   logic            need_wait;
   logic            start;

   // bank number: only the masked top address bits are compared
   function automatic logic [3:0] bank_of(input logic [AW-1:0] a,
                                          input logic [3:0]    m);
      bank_of = a[AW-1 -: 4] & m;
   endfunction

   // true for program or data space, never for io
   function automatic logic is_mem(input logic [1:0] s);
      is_mem = (s == SPACE_PROG) || (s == SPACE_DATA);
   endfunction

   // crossing detection against the previous access
   assign bank_cross  = have_last && (cpu_space == last_space) && is_mem(cpu_space)
                        && (bank_of(cpu_addr, bank_compare_mask)
                            != bank_of(last_addr, bank_compare_mask));
   assign space_cross = have_last && is_mem(cpu_space) && is_mem(last_space)
                        && (cpu_space != last_space);
   assign read_turn   = prog_data_read_gap && space_cross && last_read
                        && ~cpu_we;
   assign need_wait   = bank_cross | space_cross | read_turn;

   // new cycles start only while the bus is switched on
   assign start = (state == SEQ_IDLE) & cpu_req & ~external_bus_off;

   // next state
   always_comb begin
      next_state = state;
      unique case (state)
         SEQ_IDLE: begin
            if (start) begin
               next_state = need_wait ? SEQ_WAIT : SEQ_ACCESS;
            end
         end
         SEQ_WAIT:   next_state = SEQ_ACCESS;
         SEQ_ACCESS: next_state = SEQ_DONE;
         SEQ_DONE:   next_state = SEQ_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= SEQ_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // capture the request and remember it for the next crossing check
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         last_addr  <= '0;
         last_space <= SPACE_PROG;
         last_read  <= 1'b0;
         have_last  <= 1'b0;
         cur_space  <= SPACE_PROG;
         cur_we     <= 1'b0;
         cur_wdata  <= '0;
      end else if (start) begin
         last_addr  <= cpu_addr;
         last_space <= cpu_space;
         last_read  <= ~cpu_we;
         have_last  <= 1'b1;
         cur_space  <= cpu_space;
         cur_we     <= cpu_we;
         cur_wdata  <= cpu_wdata;
      end
   end

   // bus goes off only once no cycle is running
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_off_active <= 1'b0;
      end else if (!external_bus_off) begin
         bus_off_active <= 1'b0;
      end else if (next_state == SEQ_IDLE) begin
         bus_off_active <= 1'b1;
      end
   end

   // external pins, all from flip-flops
   logic in_cycle;
   logic strobe_next;

   assign in_cycle    = (next_state == SEQ_WAIT) || (next_state == SEQ_ACCESS);
   assign strobe_next = (next_state == SEQ_ACCESS);

   // address holds its last value whenever no cycle is running
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_addr <= '0;
      end else if (start) begin
         ext_addr <= cpu_addr;
      end
   end

   // selects, strobes, direction and data drive
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prog_sel_n   <= 1'b1;
         data_sel_n   <= 1'b1;
         io_sel_n     <= 1'b1;
         mem_strobe_n <= 1'b1;
         io_strobe_n  <= 1'b1;
         rw_n         <= 1'b1;
         ext_data_oe  <= 1'b0;
         ext_data_o   <= '0;
      end else begin
         prog_sel_n   <= ~(in_cycle && next_space() == SPACE_PROG);
         data_sel_n   <= ~(in_cycle && next_space() == SPACE_DATA);
         io_sel_n     <= ~(in_cycle && next_space() == SPACE_IO);
         mem_strobe_n <= ~(strobe_next && is_mem(cur_space));
         io_strobe_n  <= ~(strobe_next && cur_space == SPACE_IO);
         rw_n         <= ~(in_cycle && next_we());
         ext_data_oe  <= in_cycle && next_we();
         ext_data_o   <= start ? cpu_wdata : cur_wdata;
      end
   end

   // space and direction of the cycle about to be driven
   function automatic logic [1:0] next_space();
      next_space = start ? cpu_space : cur_space;
   endfunction

   function automatic logic next_we();
      next_we = start ? cpu_we : cur_we;
   endfunction

   // read data taken at the end of the strobe, ready one cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu_rdata <= '0;
         cpu_ready <= 1'b0;
      end else begin
         cpu_ready <= (state == SEQ_ACCESS);
         if (state == SEQ_ACCESS && !cur_we) begin
            cpu_rdata <= ext_data_i;
         end
      end
   end

   // boot select, host interrupt, shared ram and write permissions
   logic ram_drop;

   assign ram_drop = ram_cpu_we & shared_ram_mode;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         boot_from_shared_ram <= 1'b0;
         host_irq_bit         <= 1'b0;
         ram_we_out           <= 1'b0;
         ram_cpu_rdata        <= '0;
         host_ram_grant       <= 1'b0;
         mode_status_wr_ok    <= 1'b0;
         hold_mode_wr_ok      <= 1'b0;
      end else begin
         boot_from_shared_ram <= ~shared_ram_boot_select_n & ~boot_mode_override;
         host_irq_bit         <= bank_wait_control_register[HIRQ_BIT];
         ram_we_out           <= ram_cpu_we & ~shared_ram_mode;
         ram_cpu_rdata        <= shared_ram_mode ? '0 : ram_cpu_rdata_in;
         host_ram_grant       <= host_ram_req & (shared_ram_mode | ~cpu_idle);
         mode_status_wr_ok    <= mode_status_wr & ~external_bus_off;
         hold_mode_wr_ok      <= hold_mode_wr & ~external_bus_off;
      end
   end

   // interrupt unit
   irq_event_if #(.N(EV_COUNT)) ev ();
   logic bus_off_seen;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_off_seen <= 1'b0;
      end else begin
         bus_off_seen <= bus_off_active;
      end
   end

   // event pulses and software controls
   assign ev.event_pulse[EV_BANK_WAIT] = start & (bank_cross | space_cross);
   assign ev.event_pulse[EV_READ_GAP]  = start & read_turn;
   assign ev.event_pulse[EV_BUS_OFF]   = bus_off_active & ~bus_off_seen;
   assign ev.event_pulse[EV_RAM_DROP]  = ram_drop;
   assign ev.clear     = (apb_wr && hit_stat) ? pwdata[EV_COUNT-1:0] : '0;
   assign ev.mask_wr   = apb_wr & hit_mask;
   assign ev.mask_data = pwdata[EV_COUNT-1:0];

   irq_unit #(.N(EV_COUNT)) irq_unit_inst (
      .clk   (clk),
      .reset (reset),
      .ev    (ev.unit),
      .irq   (irq)
   );

   // read mux
   logic [31:0] rd_word;
   logic [2:0]  bus_status;

   assign bus_status = {state != SEQ_IDLE, boot_from_shared_ram, bus_off_active};
   assign rd_word    = hit_ctrl ? {16'h0000, bank_wait_control_register} :
                       hit_stat ? {28'h000_0000, ev.status} :
                       hit_mask ? {28'h000_0000, ev.mask} :
                       hit_bus  ? {29'h000_0000, bus_status} : 32'h0000_0000;

   assign prdata = apb_rd ? rd_word : 32'h0000_0000;

endmodule

// File: bench/bank_wait_ctrl_asserts.sv
// Purpose: port-level checks of the bank wait and host port control block
// Assumes: a shadow of the control word follows accepted apb writes
// Notes:   bound into every bank_wait_ctrl instance
`timescale 1ns/10ps
module bank_wait_ctrl_asserts
   import bank_ctrl_pkg::*;
#(
   parameter int AW = 16,
   parameter int DW = 16
) (
   input wire logic          clk,
   input wire logic          reset,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [11:0]   paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic [AW-1:0] ext_addr,
   input wire logic          ext_data_oe,
   input wire logic          prog_sel_n,
   input wire logic          data_sel_n,
   input wire logic          mem_strobe_n,
   input wire logic          rw_n,
   input wire logic          shared_ram_boot_select_n,
   input wire logic          boot_from_shared_ram,
   input wire logic          host_irq_bit,
   input wire logic          ram_cpu_we,
   input wire logic          ram_we_out,
   input wire logic [DW-1:0] ram_cpu_rdata,
   input wire logic          host_ram_req,
   input wire logic          host_ram_grant,
   input wire logic          mode_status_wr,
   input wire logic          mode_status_wr_ok,
   input wire logic          hold_mode_wr,
   input wire logic          hold_mode_wr_ok
);
   logic [15:0] sh;

   // shadow of the control word, loaded by accepted writes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sh <= CTRL_RESET;
      end else if (psel && penable && pwrite && paddr == OFS_CTRL) begin
         sh <= pwdata[15:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // control word readback, register line, boot select, shared ram port, bus off pins and mode lock
   property p_read_ctrl; psel && penable && !pwrite && paddr == OFS_CTRL |->
      prdata == {16'h0000, sh}; endproperty
   a_read_ctrl: assert property (p_read_ctrl) else $error("control word readback wrong");
   property p_irq_line; 1'b1 |=> host_irq_bit == $past(sh[HIRQ_BIT]); endproperty
   a_irq_line: assert property (p_irq_line) else $error("host line not following bit");
   property p_boot_high; shared_ram_boot_select_n |=> !boot_from_shared_ram; endproperty
   a_boot_high: assert property (p_boot_high) else $error("boot mode with pin high");
   property p_boot_low; !reset && !shared_ram_boot_select_n |=>
      boot_from_shared_ram == !$past(sh[BOOT_BIT]); endproperty
   a_boot_low: assert property (p_boot_low) else $error("boot mode ignores override");
   property p_ram_drop; sh[MODE_BIT] |=> !ram_we_out && ram_cpu_rdata == '0; endproperty
   a_ram_drop: assert property (p_ram_drop) else $error("cpu ram access in host mode");
   property p_ram_share; !sh[MODE_BIT] && ram_cpu_we |=> ram_we_out; endproperty
   a_ram_share: assert property (p_ram_share) else $error("shared mode write lost");
   property p_host_grant; sh[MODE_BIT] && host_ram_req |=> host_ram_grant; endproperty
   a_host_grant: assert property (p_host_grant) else $error("host refused in host mode");
   property p_bus_off; sh[BOFF_BIT] [*8] |-> mem_strobe_n && prog_sel_n && data_sel_n && rw_n
      && !ext_data_oe && $stable(ext_addr); endproperty
   a_bus_off: assert property (p_bus_off) else $error("bus pins active while off");
   property p_mode_lock; (mode_status_wr || hold_mode_wr) && sh[BOFF_BIT] |=>
      !mode_status_wr_ok && !hold_mode_wr_ok; endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode write allowed with bus off");
endmodule

bind bank_wait_ctrl bank_wait_ctrl_asserts #(.AW(AW), .DW(DW)) bank_wait_ctrl_asserts_inst (
   .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .ext_addr, .ext_data_oe,
   .prog_sel_n, .data_sel_n, .mem_strobe_n, .rw_n, .shared_ram_boot_select_n,
   .boot_from_shared_ram, .host_irq_bit, .ram_cpu_we, .ram_we_out, .ram_cpu_rdata,
   .host_ram_req, .host_ram_grant, .mode_status_wr, .mode_status_wr_ok, .hold_mode_wr,
   .hold_mode_wr_ok);

// File: bench/ext_mem_model.sv
// Purpose: external memory on the far side of the bus
// Assumes: read data is the inverted address
// Notes:   an undriven bus shows a changing pattern
`timescale 1ns/10ps
module ext_mem_model (
   input  wire logic        clk,
   input  wire logic [15:0] ext_addr,
   input  wire logic        mem_strobe_n,
   input  wire logic        rw_n,
   input  wire logic        ext_data_oe,
   input  wire logic [15:0] ext_data_o,
   output logic      [15:0] ext_data_i
);
   logic [15:0] churn = 16'h0000;

   // pattern that changes every cycle stands for a floating bus
   always_ff @(posedge clk) begin
      churn <= churn + 16'h1357;
   end

   // memory answers only during a read strobe
   assign ext_data_i = ext_data_oe ? ext_data_o : (!mem_strobe_n && rw_n) ? ~ext_addr : churn;
endmodule

// File: bench/bank_wait_ctrl_tb.sv
// Purpose: self-checking bench for the bank wait and host port control block
// Assumes: zero-wait apb slave, memory model on the external bus
// Notes:   latency counts clock edges from the request edge
`timescale 1ns/10ps
module bank_wait_ctrl_tb
   import bank_ctrl_pkg::*;
;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        cpu_req, cpu_we, cpu_ready, ext_data_oe, prog_sel_n, data_sel_n;
   logic        io_sel_n, mem_strobe_n, io_strobe_n, rw_n, boot_n, boot, hirq, irq;
   logic        ram_cpu_we, ram_we_out, cpu_idle, host_req, grant, ms_wr, ms_ok, hm_wr, hm_ok;
   logic [1:0]  cpu_space;
   logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, ext_addr, ext_data_o, ext_data_i;
   logic [15:0] ram_in, ram_rdata;
   logic [3:0]  enc [5] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF};
   int          n_errors, checks_done, cyc, lat;

   bank_wait_ctrl bank_wait_ctrl_inst (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_req(cpu_req), .cpu_space(cpu_space), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
      .ext_addr(ext_addr), .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
      .ext_data_i(ext_data_i), .prog_sel_n(prog_sel_n), .data_sel_n(data_sel_n),
      .io_sel_n(io_sel_n), .mem_strobe_n(mem_strobe_n), .io_strobe_n(io_strobe_n),
      .rw_n(rw_n), .shared_ram_boot_select_n(boot_n), .boot_from_shared_ram(boot),
      .host_irq_bit(hirq), .ram_cpu_we(ram_cpu_we), .ram_cpu_rdata_in(ram_in),
      .ram_we_out(ram_we_out), .ram_cpu_rdata(ram_rdata), .cpu_idle(cpu_idle),
      .host_ram_req(host_req), .host_ram_grant(grant), .mode_status_wr(ms_wr),
      .mode_status_wr_ok(ms_ok), .hold_mode_wr(hm_wr), .hold_mode_wr_ok(hm_ok), .irq(irq));

   ext_mem_model ext_mem_model_inst (
      .clk(clk), .ext_addr(ext_addr), .mem_strobe_n(mem_strobe_n), .rw_n(rw_n),
      .ext_data_oe(ext_data_oe), .ext_data_o(ext_data_o), .ext_data_i(ext_data_i));

   // clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000);
      chk(rd, e);
   endtask

   // processor read on the external bus, latency left in lat
   task automatic cpu_rd(input logic [1:0] s, input logic [15:0] a);
      int n = 0;
      @(posedge clk);
      cpu_req <= 1'b1;
      cpu_space <= s;
      cpu_addr <= a;
      do begin
         @(posedge clk);
         n++;
      end while (cpu_ready !== 1'b1 && n < 40);
      lat = n;
      cpu_req <= 1'b0;
      chk({16'h0000, cpu_rdata}, {16'h0000, ~a});
   endtask

   initial begin
      {reset, psel, penable, pwrite, cpu_req, cpu_we, ram_cpu_we} = 7'h7F & 7'h40;
      {boot_n, cpu_idle, host_req, ms_wr, hm_wr} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cpu_space = 2'b00;
      {cpu_addr, cpu_wdata, ram_in} = 48'h0000_0000_0000;
      {n_errors, checks_done, cyc, lat} = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      rdchk(OFS_CTRL, 32'h0000_F800);
      rdchk(OFS_IRQ_MASK, 32'h0000_0000);
      chk(boot, 1'b1);
      apb(OFS_CTRL, 1'b1, 32'h0000_F7E2);
      rdchk(OFS_CTRL, 32'h0000_F7E2);
      rdchk(12'h010, 32'h0000_0000);
      chk(rerr, 1'b1);
      // boot pin, override and a reset in mid-run
      boot_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(boot, 1'b0);
      apb(OFS_CTRL, 1'b1, 32'h0000_F810);
      boot_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(boot, 1'b0);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      chk(boot, 1'b1);
      rdchk(OFS_CTRL, 32'h0000_F800);
      // host interrupt pulse made by software
      apb(OFS_CTRL, 1'b1, 32'h0000_F808);
      repeat (4) @(posedge clk);
      chk(hirq, 1'b1);
      apb(OFS_CTRL, 1'b1, 32'h0000_F800);
      repeat (2) @(posedge clk);
      chk(hirq, 1'b0);
      // shared ram in both modes, dropped write raises the interrupt
      ram_in <= 16'hA5C3;
      ram_cpu_we <= 1'b1;
      cpu_idle <= 1'b1;
      host_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(ram_we_out, 1'b1);
      chk({16'h0000, ram_rdata}, 32'h0000_A5C3);
      apb(OFS_IRQ_MASK, 1'b1, 32'h0000_0008);
      apb(OFS_CTRL, 1'b1, 32'h0000_F804);
      repeat (2) @(posedge clk);
      chk(ram_we_out, 1'b0);
      chk({16'h0000, ram_rdata}, 32'h0000_0000);
      chk(grant, 1'b1);
      ram_cpu_we <= 1'b0;
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      rdchk(OFS_IRQ_STATUS, 32'h0000_0008);
      apb(OFS_IRQ_MASK, 1'b1, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      apb(OFS_IRQ_STATUS, 1'b1, 32'h0000_0008);
      rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
      // every bank size: crossing bit 15, then bit 12
      for (int k = 0; k < 5; k++) begin
         apb(OFS_CTRL, 1'b1, {16'h0000, enc[k], 12'h800});
         cpu_rd(SPACE_PROG, 16'h0000);
         cpu_rd(SPACE_PROG, 16'h8000);
         chk(lat, 3 + (k > 0));
         cpu_rd(SPACE_PROG, 16'h9000);
         chk(lat, 3 + (k == 4));
      end
      cpu_rd(SPACE_DATA, 16'h9000);
      chk(lat, 4);
      // bus off: requests refused, mode writes blocked
      ms_wr <= 1'b1;
      hm_wr <= 1'b1;
      apb(OFS_CTRL, 1'b1, 32'h0000_F001);
      repeat (2) @(posedge clk);
      chk({ms_ok, hm_ok}, 2'b00);
      rdchk(OFS_BUS_STATUS, 32'h0000_0003);
      rdchk(OFS_IRQ_STATUS, 32'h0000_0007);
      cpu_req <= 1'b1;
      cpu_space <= SPACE_DATA;
      cpu_addr <= 16'h4321;
      repeat (20) begin
         @(posedge clk);
         chk({cpu_ready, mem_strobe_n, io_strobe_n, io_sel_n, ext_data_oe}, 5'h0E);
      end
      apb(OFS_CTRL, 1'b1, 32'h0000_F000);
      repeat (2) @(posedge clk);
      chk({ms_ok, hm_ok}, 2'b11);
      cpu_rd(SPACE_DATA, 16'h4321);
      print_verdict();
   end
endmodule
